// [hw/sdr_consts.svh]
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH
// ****************************************
// word and clocking
// ****************************************
`define SDR_WORD_BITS      24
`define SDR_CLK_HZ         40000000
`define SDR_CLK_NS         25
`define SDR_CRYSTAL_OSCILLATOR_HZ        32768
`define SDR_CRYSTAL_OSCILLATOR_HALF_CYC  (`SDR_CLK_HZ / (2 * `SDR_CRYSTAL_OSCILLATOR_HZ))
// ****************************************
// conversion
// ****************************************
`define SDR_DEC_A          69
`define SDR_DEC_B          8
`define SDR_DEC_C          3
`define SDR_SETTLE_RES     2
`define SDR_LOCK_CRYSTAL_OSCILLATOR      4
`define SDR_AVG_MUL        1266
`define SDR_AVG_SHR        21
`define SDR_GAIN_SHL       4
`define SDR_CODE_MID       24'h800000
`define SDR_PIN_RST        6'h21
// ****************************************
// host link timing
// ****************************************
`define SDR_HOST_HALF      4
`define SDR_HOST_BURST     8
`define SDR_HOST_GAP       8
`endif

// [hw/sdr_pkg.sv]
package sdr_pkg;
  typedef enum logic [1:0] {SDR_C_OFF, SDR_C_LOCK, SDR_C_RUN} sdr_conv_st_t;
  typedef enum logic [2:0] {SDR_L_IDLE, SDR_L_UPD, SDR_L_RDY, SDR_L_SHIFT} sdr_lnk_st_t;
  typedef enum logic [2:0] {SDR_H_OFF, SDR_H_WAIT, SDR_H_LOW, SDR_H_HIGH, SDR_H_GAP, SDR_H_DONE} sdr_host_st_t;
endpackage

// [hw/sdr_link_if.sv]
`timescale 1ns/1ps
interface sdr_link_if;
  logic cs_n;
  logic mode;
  logic channel_pick;
  logic gain_range;
  logic sclk_o;
  logic sclk_oe_n;
  logic sclk_h;
  logic sclk_h_oe_n;
  logic dout;
  logic dout_oe_n;
  logic sclk;
  logic dout_line;
  // released lines float high, as with a pull-up
  assign sclk      = !sclk_oe_n ? sclk_o : (!sclk_h_oe_n ? sclk_h : 1'b1);
  assign dout_line = !dout_oe_n ? dout : 1'b1;
  modport dev (input cs_n, mode, channel_pick, gain_range, sclk, output sclk_o, sclk_oe_n, dout, dout_oe_n);
  modport hst (input sclk, dout_line, output cs_n, mode, channel_pick, gain_range, sclk_h, sclk_h_oe_n);
endinterface

// [hw/sdr_dev_end.sv]
`timescale 1ns/1ps
`include "sdr_consts.svh"
module sdr_dev_end #(
  parameter int CRYSTAL_OSCILLATOR_HALF = `SDR_CRYSTAL_OSCILLATOR_HALF_CYC,
  parameter int LOCK_CRYSTAL_OSCILLATOR = `SDR_LOCK_CRYSTAL_OSCILLATOR
) (
  input  wire logic                      CLK_I,
  input  wire logic                      RESET_N_I,
  input  wire logic [`SDR_WORD_BITS-1:0] SAMPLE_I,
  output logic                           STANDBY_O,
  output logic                           INPUT_PAIR_TWO_O,
  output logic                           GAIN16_O,
  sdr_link_if.dev                        LNK
);
  localparam int W         = `SDR_WORD_BITS;
  localparam int CONV_CRYSTAL_OSCILLATOR = `SDR_DEC_A * `SDR_DEC_B * `SDR_DEC_C;
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic       cnt24;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_s1 <= `SDR_PIN_RST;
      pin_s2 <= `SDR_PIN_RST;
    end else begin
      pin_s1 <= {LNK.cs_n, LNK.mode, LNK.channel_pick, LNK.gain_range, cnt24, LNK.sclk};
      pin_s2 <= pin_s1;
    end
  end
  wire cs_act   = !pin_s2[5];
  wire slave    = pin_s2[4];
  wire ch       = pin_s2[3];
  wire rng      = pin_s2[2];
  wire cnt24_s  = pin_s2[1];
  wire sclk_s   = pin_s2[0];
  // ****************************************
  // crystal period timebase
  // ****************************************
  logic [15:0] hcnt;
  logic        xph;
  wire half_tick = hcnt == 16'(CRYSTAL_OSCILLATOR_HALF - 1);
  wire crystal_oscillator_tick = half_tick && xph;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hcnt <= 16'h0000;
      xph  <= 1'b0;
    end else begin
      hcnt <= half_tick ? 16'h0000 : hcnt + 16'h0001;
      xph  <= xph ^ half_tick;
    end
  end
  // ****************************************
  // conversion and filter
  // ****************************************
  // boxcar over one output period: zeros at multiples of the rate
  function automatic logic [W-1:0] to_code(input logic signed [35:0] sum, input logic hi_gain);
    logic signed [47:0] avg;
    logic signed [47:0] g;
    avg = (48'(sum) * 48'sd`SDR_AVG_MUL) >>> `SDR_AVG_SHR;
    g   = hi_gain ? (avg <<< `SDR_GAIN_SHL) : avg;
    if (g > 48'sh7fffff) begin
      to_code = {W{1'b1}};
    end else if (g < -48'sh800000) begin
      to_code = {W{1'b0}};
    end else begin
      to_code = g[W-1:0] ^ `SDR_CODE_MID;
    end
  endfunction
  sdr_pkg::sdr_conv_st_t cst;
  logic [15:0]           xcnt;
  logic signed [35:0]    acc;
  logic [1:0]            settle;
  logic                  ch_prev;
  logic                  conv_done;
  logic [W-1:0]          result;
  wire signed [35:0] next_acc = acc + 36'(signed'(SAMPLE_I));
  wire ch_chg   = ch != ch_prev;
  wire conv_end = cst == sdr_pkg::SDR_C_RUN && crystal_oscillator_tick && xcnt == 16'(CONV_CRYSTAL_OSCILLATOR - 1);
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cst       <= sdr_pkg::SDR_C_OFF;
      xcnt      <= 16'h0000;
      acc       <= 36'sh0;
      settle    <= 2'h0;
      ch_prev   <= 1'b0;
      conv_done <= 1'b0;
      result    <= {W{1'b0}};
    end else begin
      ch_prev   <= ch;
      conv_done <= cs_act && conv_end && settle == 2'h0 && !ch_chg;
      if (!cs_act) begin
        settle <= 2'h0;
      end else if (ch_chg) begin
        settle <= 2'(`SDR_SETTLE_RES);
      end else if (conv_end && settle != 2'h0) begin
        settle <= settle - 2'h1;
      end
      if (!cs_act) begin
        cst  <= sdr_pkg::SDR_C_OFF;
        xcnt <= 16'h0000;
        acc  <= 36'sh0;
      end else begin
        unique case (cst)
          sdr_pkg::SDR_C_OFF: begin
            cst  <= sdr_pkg::SDR_C_LOCK;
            xcnt <= 16'h0000;
          end
          sdr_pkg::SDR_C_LOCK: begin
            if (crystal_oscillator_tick) begin
              xcnt <= xcnt + 16'h0001;
              if (xcnt == 16'(LOCK_CRYSTAL_OSCILLATOR - 1)) begin
                cst  <= sdr_pkg::SDR_C_RUN;
                xcnt <= 16'h0000;
                acc  <= 36'sh0;
              end
            end
          end
          sdr_pkg::SDR_C_RUN: begin
            if (conv_end) begin
              xcnt   <= 16'h0000;
              acc    <= 36'sh0;
              result <= to_code(next_acc, !rng);
            end else if (crystal_oscillator_tick) begin
              xcnt <= xcnt + 16'h0001;
              acc  <= next_acc;
            end
          end
        endcase
      end
    end
  end
  // ****************************************
  // link control, crystal side
  // ****************************************
  sdr_pkg::sdr_lnk_st_t lst;
  logic                 dout_q;
  logic                 sclk_q;
  logic [W-1:0]         word;
  logic [W-1:0]         sh;
  logic [4:0]           bcnt;
  logic [15:0]          tcnt;
  logic                 slv_clr;
  logic                 dout_oe_n;
  logic                 sclk_oe_n;
  wire t_end = tcnt == 16'(CRYSTAL_OSCILLATOR_HALF - 1);
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lst    <= sdr_pkg::SDR_L_IDLE;
      dout_q <= 1'b1;
      sclk_q <= 1'b1;
      word   <= {W{1'b0}};
      sh     <= {W{1'b0}};
      bcnt   <= 5'h00;
      tcnt   <= 16'h0000;
    end else if (!cs_act) begin
      lst    <= sdr_pkg::SDR_L_IDLE;
      dout_q <= 1'b1;
      sclk_q <= 1'b1;
      word   <= {W{1'b0}};
    end else begin
      tcnt <= t_end ? 16'h0000 : tcnt + 16'h0001;
      unique case (lst)
        sdr_pkg::SDR_L_IDLE: begin
          dout_q <= 1'b1;
          if (conv_done) begin
            lst <= sdr_pkg::SDR_L_UPD;
          end
        end
        sdr_pkg::SDR_L_UPD: begin
          word   <= result;
          dout_q <= 1'b0;
          tcnt   <= 16'h0000;
          lst    <= sdr_pkg::SDR_L_RDY;
        end
        sdr_pkg::SDR_L_RDY: begin
          if (conv_done) begin
            dout_q <= 1'b1;
            lst    <= sdr_pkg::SDR_L_UPD;
          end else if (slave && cnt24_s && sclk_s) begin
            dout_q <= 1'b1;
            lst    <= sdr_pkg::SDR_L_IDLE;
          end else if (!slave && t_end) begin
            sclk_q <= 1'b0;
            dout_q <= word[W-1];
            sh     <= word;
            bcnt   <= 5'h00;
            lst    <= sdr_pkg::SDR_L_SHIFT;
          end
        end
        sdr_pkg::SDR_L_SHIFT: begin
          // a result finishing mid-word is dropped; the word is far shorter than a period
          if (t_end && !sclk_q) begin
            sclk_q <= 1'b1;
          end else if (t_end && bcnt == 5'(W - 1)) begin
            dout_q <= 1'b1;
            lst    <= sdr_pkg::SDR_L_IDLE;
          end else if (t_end) begin
            sclk_q <= 1'b0;
            dout_q <= sh[W-2];
            sh     <= {sh[W-2:0], 1'b0};
            bcnt   <= bcnt + 5'h01;
          end
        end
        default: begin
          lst <= sdr_pkg::SDR_L_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      slv_clr          <= 1'b1;
      dout_oe_n        <= 1'b1;
      sclk_oe_n        <= 1'b1;
      STANDBY_O        <= 1'b1;
      INPUT_PAIR_TWO_O <= 1'b0;
      GAIN16_O         <= 1'b1;
    end else begin
      slv_clr          <= !(slave && lst == sdr_pkg::SDR_L_RDY);
      dout_oe_n        <= !cs_act;
      sclk_oe_n        <= !(cs_act && !slave);
      STANDBY_O        <= !cs_act;
      INPUT_PAIR_TWO_O <= ch;
      GAIN16_O         <= !rng;
    end
  end
  // ****************************************
  // link shifter, host clock side
  // ****************************************
  // word holds still through a ready window, so reading it here is safe
  logic [4:0] scnt;
  logic       sdout;
  always_ff @(negedge LNK.sclk or posedge slv_clr) begin
    if (slv_clr) begin
      scnt  <= 5'h00;
      sdout <= 1'b0;
      cnt24 <= 1'b0;
    end else if (!cnt24) begin
      sdout <= word[5'(W - 1) - scnt];
      scnt  <= scnt + 5'h01;
      cnt24 <= scnt == 5'(W - 1);
    end
  end
  assign LNK.dout      = (slave && lst == sdr_pkg::SDR_L_RDY) ? sdout : dout_q;
  assign LNK.dout_oe_n = dout_oe_n;
  assign LNK.sclk_o    = sclk_q;
  assign LNK.sclk_oe_n = sclk_oe_n;
endmodule

// [hw/sdr_host_end.sv]
`timescale 1ns/1ps
`include "sdr_consts.svh"
module sdr_host_end #(
  parameter int HALF  = `SDR_HOST_HALF,
  parameter int BURST = `SDR_HOST_BURST,
  parameter int GAP   = `SDR_HOST_GAP
) (
  input  wire logic                      CLK_I,
  input  wire logic                      RESET_N_I,
  input  wire logic                      ENABLE_I,
  input  wire logic                      SLAVE_I,
  input  wire logic                      CHANNEL_I,
  input  wire logic                      RANGE_I,
  output logic [`SDR_WORD_BITS-1:0]      DATA_O,
  output logic                           DATA_VALID_O,
  sdr_link_if.hst                        LNK
);
  localparam int W = `SDR_WORD_BITS;
  // ****************************************
  // line synchronisers
  // ****************************************
  logic [1:0] s1;
  logic [1:0] s2;
  logic       sclk_prev;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s1        <= 2'h3;
      s2        <= 2'h3;
      sclk_prev <= 1'b1;
    end else begin
      s1        <= {LNK.dout_line, LNK.sclk};
      s2        <= s1;
      sclk_prev <= s2[0];
    end
  end
  wire dout_s = s2[1];
  wire rise_s = s2[0] && !sclk_prev;

  // ****************************************
  // reader
  // ****************************************
  // half period must cover the two-flop lag on the data line
  sdr_pkg::sdr_host_st_t hst;
  logic [15:0]           tcnt;
  logic [4:0]            bits;
  logic [4:0]            bcnt;
  logic [W-1:0]          shreg;
  logic [1:0]            settle;
  logic                  sclk_h;
  wire t_end = tcnt == 16'(HALF - 1);
  wire chg   = CHANNEL_I != LNK.channel_pick;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hst           <= sdr_pkg::SDR_H_OFF;
      tcnt          <= 16'h0000;
      bits          <= 5'h00;
      bcnt          <= 5'h00;
      shreg         <= {W{1'b0}};
      settle        <= 2'h0;
      sclk_h        <= 1'b1;
      DATA_O        <= {W{1'b0}};
      DATA_VALID_O  <= 1'b0;
      LNK.cs_n      <= 1'b1;
      LNK.mode      <= 1'b0;
      LNK.channel_pick <= 1'b0;
      LNK.gain_range   <= 1'b0;
      LNK.sclk_h_oe_n  <= 1'b1;
    end else begin
      DATA_VALID_O     <= 1'b0;
      LNK.mode         <= SLAVE_I;
      LNK.channel_pick <= CHANNEL_I;
      LNK.gain_range   <= RANGE_I;
      LNK.sclk_h_oe_n  <= !(SLAVE_I && ENABLE_I);
      tcnt <= t_end ? 16'h0000 : tcnt + 16'h0001;
      if (chg) begin
        settle <= 2'(`SDR_SETTLE_RES);
      end
      if (!ENABLE_I) begin
        hst      <= sdr_pkg::SDR_H_OFF;
        LNK.cs_n <= 1'b1;
        sclk_h   <= 1'b1;
      end else begin
        unique case (hst)
          sdr_pkg::SDR_H_OFF: begin
            LNK.cs_n <= 1'b0;
            hst      <= sdr_pkg::SDR_H_DONE;
          end
          sdr_pkg::SDR_H_WAIT: begin
            bits <= 5'h00;
            bcnt <= 5'h00;
            tcnt <= 16'h0000;
            if (SLAVE_I && !dout_s) begin
              sclk_h <= 1'b0;
              hst    <= sdr_pkg::SDR_H_LOW;
            end else if (!SLAVE_I && !dout_s) begin
              hst <= sdr_pkg::SDR_H_HIGH;
            end
          end
          sdr_pkg::SDR_H_LOW: begin
            if (t_end) begin
              sclk_h <= 1'b1;
              shreg  <= {shreg[W-2:0], dout_s};
              bits   <= bits + 5'h01;
              bcnt   <= bcnt + 5'h01;
              hst    <= sdr_pkg::SDR_H_HIGH;
            end
          end
          sdr_pkg::SDR_H_HIGH: begin
            if (!SLAVE_I && rise_s) begin
              shreg <= {shreg[W-2:0], dout_s};
              bits  <= bits + 5'h01;
            end
            if (bits == 5'(W)) begin
              DATA_O       <= shreg;
              DATA_VALID_O <= settle == 2'h0 && !chg;
              if (settle != 2'h0 && !chg) begin
                settle <= settle - 2'h1;
              end
              hst <= sdr_pkg::SDR_H_DONE;
            end else if (SLAVE_I && t_end && bcnt == 5'(BURST)) begin
              bcnt <= 5'h00;
              hst  <= sdr_pkg::SDR_H_GAP;
            end else if (SLAVE_I && t_end) begin
              sclk_h <= 1'b0;
              hst    <= sdr_pkg::SDR_H_LOW;
            end
          end
          sdr_pkg::SDR_H_GAP: begin
            sclk_h <= 1'b1;
            tcnt   <= tcnt + 16'h0001; // gap outlasts the half-period wrap
            if (tcnt == 16'(GAP - 1)) begin
              tcnt   <= 16'h0000;
              sclk_h <= 1'b0;
              hst    <= sdr_pkg::SDR_H_LOW;
            end
          end
          sdr_pkg::SDR_H_DONE: begin
            sclk_h <= 1'b1;
            if (dout_s) begin
              hst <= sdr_pkg::SDR_H_WAIT;
            end
          end
          default: begin
            hst <= sdr_pkg::SDR_H_OFF;
          end
        endcase
      end
    end
  end
  assign LNK.sclk_h = sclk_h;
endmodule

// [verification/sdr_link_sva.sv]
`timescale 1ns/1ps
module sdr_link_sva #(
  parameter int CRYSTAL_OSCILLATOR_HALF = 4
) (
  input  wire logic CLK_I,
  input  wire logic RESET_N_I,
  input  wire logic cs_n,
  input  wire logic mode,
  input  wire logic sclk,
  input  wire logic sclk_oe_n,
  input  wire logic dout_oe_n,
  input  wire logic dout_line
);
  // ****************************************
  // helper counters on the link lines
  // ****************************************
  // a high run longer than a host batch gap means the word is over
  localparam int IDLE_LIM = 4 * CRYSTAL_OSCILLATOR_HALF + 8;
  localparam int RET_MAX  = CRYSTAL_OSCILLATOR_HALF + 3;
  logic       sclk_q;
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic [7:0] rdy_cnt;
  logic [5:0] nfall;
  wire        sclk_fall  = sclk_q && !sclk;
  wire        idle_hit   = (hi_cnt == IDLE_LIM[7:0]);
  wire [7:0]  next_hi    = !sclk ? 8'h00 : ((hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01);
  wire [7:0]  next_lo    = sclk ? 8'h00 : ((lo_cnt == 8'hff) ? lo_cnt : lo_cnt + 8'h01);
  wire [7:0]  next_rdy   = dout_line ? 8'h00 : ((rdy_cnt == 8'hff) ? rdy_cnt : rdy_cnt + 8'h01);
  wire [5:0]  next_nfall = sclk_fall ? nfall + 6'h01 : (idle_hit ? 6'h00 : nfall);

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sclk_q  <= 1'b1;
      hi_cnt  <= 8'h00;
      lo_cnt  <= 8'h00;
      rdy_cnt <= 8'h00;
      nfall   <= 6'h00;
    end else begin
      sclk_q  <= sclk;
      hi_cnt  <= next_hi;
      lo_cnt  <= next_lo;
      rdy_cnt <= next_rdy;
      nfall   <= next_nfall;
    end
  end

  // ****************************************
  // link properties
  // ****************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // select is synchronised first, so allow a few cycles
  chk_lines_release: assert property (cs_n [*6] |-> dout_oe_n && sclk_oe_n)
    else $error("link lines still driven while deselected");
  chk_slave_listen: assert property (mode [*6] |-> sclk_oe_n)
    else $error("device drives shift clock in slave mode");
  chk_master_only: assert property (!sclk_oe_n |-> !mode)
    else $error("shift clock driven outside master mode");
  chk_word_edges: assert property ((!mode && idle_hit) |-> (nfall == 6'h00 || nfall == 6'h18))
    else $error("master word did not have 24 clock edges");
  chk_low_half: assert property ((!mode && !sclk_oe_n && $rose(sclk)) |-> lo_cnt == CRYSTAL_OSCILLATOR_HALF)
    else $error("master clock low half wrong length");
  chk_high_half: assert property ((!mode && !sclk_oe_n && $fell(sclk) && nfall != 6'h00) |-> hi_cnt == CRYSTAL_OSCILLATOR_HALF)
    else $error("master clock high half wrong length");
  chk_ready_lead: assert property ((!mode && !sclk_oe_n && $fell(sclk) && nfall == 6'h00) |-> rdy_cnt >= CRYSTAL_OSCILLATOR_HALF)
    else $error("ready low too briefly before clocking");
  chk_ready_return: assert property ((!mode && !sclk_oe_n && $rose(sclk) && nfall == 6'h18) |-> ##[1:RET_MAX] dout_line)
    else $error("data line did not return high after word");
  chk_data_edge: assert property ((!mode && !dout_oe_n && $changed(dout_line)) |-> (!sclk || hi_cnt >= CRYSTAL_OSCILLATOR_HALF))
    else $error("data changed during clock high half");

  cover property (!mode && idle_hit && nfall == 6'h18);
  cover property (mode && idle_hit && nfall == 6'h18);
  cover property ($rose(cs_n));
endmodule

// [verification/test_sigma_delta_adc_serial_readout.sv]
`timescale 1ns/1ps
`include "sdr_consts.svh"
module test_sigma_delta_adc_serial_readout;
  // ****************************************
  // clocks, stimulus and the two ends
  // ****************************************
  // short crystal half keeps eight conversions inside the run
  localparam int XH      = 1;
  localparam int CONV_NS = XH * 2 * `SDR_DEC_A * `SDR_DEC_B * `SDR_DEC_C * 48;
  logic        clk        = 1'b0;
  logic        lclk       = 1'b0;
  logic        rst_n      = 1'b0;
  logic        enable     = 1'b0;
  logic        slave      = 1'b0;
  logic        channel    = 1'b0;
  logic        range      = 1'b0;
  logic [23:0] sample     = 24'h000000;
  logic [23:0] data;
  logic        data_valid;
  logic        standby;
  logic        pair_two;
  logic        gain16;
  int          num_errors = 0;
  int          compares   = 0;

  always #12.5 clk = ~clk;
  always #24 lclk = ~lclk;

  sdr_link_if lnk ();

  sdr_dev_end #(.CRYSTAL_OSCILLATOR_HALF(XH), .LOCK_CRYSTAL_OSCILLATOR(1)) u_sdr_dev_end (
    .CLK_I            (lclk),
    .RESET_N_I        (rst_n),
    .SAMPLE_I         (sample),
    .STANDBY_O        (standby),
    .INPUT_PAIR_TWO_O (pair_two),
    .GAIN16_O         (gain16),
    .LNK              (lnk)
  );

  sdr_host_end u_sdr_host_end (
    .CLK_I        (clk),
    .RESET_N_I    (rst_n),
    .ENABLE_I     (enable),
    .SLAVE_I      (slave),
    .CHANNEL_I    (channel),
    .RANGE_I      (range),
    .DATA_O       (data),
    .DATA_VALID_O (data_valid),
    .LNK          (lnk)
  );

  sdr_link_sva #(.CRYSTAL_OSCILLATOR_HALF(XH)) u_sdr_link_sva (
    .CLK_I     (lclk),
    .RESET_N_I (rst_n),
    .cs_n      (lnk.cs_n),
    .mode      (lnk.mode),
    .sclk      (lnk.sclk),
    .sclk_oe_n (lnk.sclk_oe_n),
    .dout_oe_n (lnk.dout_oe_n),
    .dout_line (lnk.dout_line)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  function automatic logic [23:0] exp_code(input longint s, input bit g16);
    longint a;
    a = (s * `SDR_DEC_A * `SDR_DEC_B * `SDR_DEC_C * `SDR_AVG_MUL) >>> `SDR_AVG_SHR;
    if (g16) begin
      a = a <<< `SDR_GAIN_SHL;
    end
    if (a > 64'sh7fffff) begin
      a = 64'sh7fffff;
    end
    if (a < -64'sh800000) begin
      a = -64'sh800000;
    end
    return a[23:0] ^ 24'h800000;
  endfunction

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // waits for ready low on the line, or for a delivered word
  task automatic wait_for(input bit on_ready, input int limit);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > limit) begin
        num_errors++;
        $display("BAD wait expected event seen timeout");
        finish_test();
      end
    end while (!(on_ready ? lnk.dout_line === 1'b0 : data_valid === 1'b1));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_master();
    time t0;
    bit  in_win;
    @(posedge lclk);
    sample <= 24'h100000;
    @(posedge clk);
    range  <= 1'b1;
    enable <= 1'b1;
    wait_for(1'b0, 20000);
    check("master word", data, exp_code(64'sh100000, 1'b0));
    check("master drives clock", {23'h0, lnk.sclk_oe_n}, 24'h000000);
    check("gain16 flag", {23'h0, gain16}, 24'h000000);
    check("standby flag", {23'h0, standby}, 24'h000000);
    t0 = $time;
    wait_for(1'b0, 14000);
    in_win = ($time - t0 > CONV_NS - 150) && ($time - t0 < CONV_NS + 150);
    check("master repeat", data, exp_code(64'sh100000, 1'b0));
    check("result spacing", {23'h0, in_win}, 24'h000001);
  endtask

  task automatic t_standby();
    @(posedge clk);
    enable <= 1'b0;
    repeat (16) @(negedge clk);
    check("standby flag", {23'h0, standby}, 24'h000001);
    check("data released", {23'h0, lnk.dout_oe_n}, 24'h000001);
    check("clock released", {23'h0, lnk.sclk_oe_n}, 24'h000001);
    check("idle clock", {23'h0, lnk.sclk}, 24'h000001);
  endtask

  task automatic t_slave();
    time t0;
    bit  settled;
    @(posedge lclk);
    sample <= 24'h010000;
    @(posedge clk);
    slave  <= 1'b1;
    range  <= 1'b0;
    enable <= 1'b1;
    wait_for(1'b1, 20000);
    check("slave clock input", {23'h0, lnk.sclk_oe_n}, 24'h000001);
    wait_for(1'b0, 2000);
    check("slave word", data, exp_code(64'sh10000, 1'b1));
    check("gain16 flag", {23'h0, gain16}, 24'h000001);
    // new pair and negative full scale at once; only settled words may come
    t0 = $time;
    @(posedge lclk);
    sample  <= 24'h800000;
    @(posedge clk);
    channel <= 1'b1;
    wait_for(1'b0, 70000);
    settled = ($time - t0) >= 2 * CONV_NS;
    check("settling wait", {23'h0, settled}, 24'h000001);
    check("pair two", {23'h0, pair_two}, 24'h000001);
    check("negative clamp", data, 24'h000000);
    repeat (40) @(negedge clk);
    check("slave idle clock", {23'h0, lnk.sclk}, 24'h000001);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_master();
    t_standby();
    t_slave();
    finish_test();
  end
endmodule
